// ---- crcv_host.sv ----
/*
 * host sequencer that issues the crc-64 verify command to a parallel
 * nor flash, polls it until ready and reports pass, fail or timeout.
 * assumes flash_ready_i and flash_dq_i are synchronous to clk_i and that
 * the device keeps its ready line low after a failed check.
 */
`default_nettype none
// Summary of operation
// - we open with two unlock writes, then the extended and crc codes.
// - we then write the count minus one and the range or chip option.
// - the expected crc goes out as four words, low byte first in x8.
// - a range check sends the start byte address low and high words.
// - a range check sends the stop byte address low and high words.
// - we finish with the confirm code and poll reads until ready, the error bit or the poll limit.
// - the whole-chip form sends the confirm right after the crc words.
module crcv_host
    import crcv_pkg::*;
#(
    parameter logic [31:0] POLL_LIMIT      = 32'h0100_0000,
    parameter logic [15:0] READ_RESET_CODE = 16'h00f0
)
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        start_i,
    input  wire logic        range_i,
    input  wire logic        byte_mode_i,
    input  wire logic [63:0] exp_crc_i,
    input  wire logic [31:0] start_addr_i,
    input  wire logic [31:0] stop_addr_i,
    input  wire logic        flash_ready_i,
    input  wire logic [15:0] flash_dq_i,
    output logic [23:0]      flash_addr_o,
    output logic [15:0]      flash_dq_o,
    output logic [15:0]      flash_dq_oe_o,
    output logic             flash_ce_n_o,
    output logic             flash_we_n_o,
    output logic             flash_oe_n_o,
    output logic             busy_o,
    output logic             done_o,
    output logic             pass_o,
    output logic             fail_o,
    output logic             timeout_o
);
    import crcv_pkg::*;

    typedef struct packed {
        crcv_st_e    st;
        logic [4:0]  k;
        logic        rng;
        logic        bm;
        logic [63:0] crc;
        logic [31:0] sa;
        logic [31:0] so;
        logic [31:0] pc;
        logic        req;
        logic        wr;
        logic [23:0] addr;
        logic [15:0] wdata;
        logic [15:0] oe;
        logic        busy;
        logic        done;
        logic        pass;
        logic        fail;
        logic        tmo;
    } crcv_top_s;

    crcv_top_s  r_r;
    crcv_top_s  r_nxt;
    crcv_wr_s   w;
    crcv_cyc_if cyc ();

    //------------------------------------------------------------------
    // command sequencing
    //------------------------------------------------------------------
    always_comb
    begin
        r_nxt      = r_r;
        r_nxt.done = 1'b0;
        w = cmd_write(r_r.k, r_r.rng, r_r.bm, r_r.crc, r_r.sa, r_r.so);
        unique case (r_r.st)
            S_IDLE:
                if (start_i)
                begin
                    r_nxt.rng  = range_i;
                    r_nxt.bm   = byte_mode_i;
                    r_nxt.crc  = exp_crc_i;
                    r_nxt.sa   = start_addr_i;
                    r_nxt.so   = stop_addr_i;
                    r_nxt.k    = STEP_UL1;
                    r_nxt.busy = 1'b1;
                    r_nxt.pass = 1'b0;
                    r_nxt.fail = 1'b0;
                    r_nxt.tmo  = 1'b0;
                    r_nxt.st   = S_ISSUE;
                end
            S_ISSUE:
            begin
                // unlock, codes, count, option, crc, addresses, confirm
                r_nxt.req   = 1'b1;
                r_nxt.wr    = 1'b1;
                r_nxt.addr  = w.waddr;
                r_nxt.wdata = r_r.bm ? {w.a_lsb, DQ_MID_PAD, w.data[7:0]}
                                     : w.data;
                r_nxt.oe    = r_r.bm ? OE_WR_B : OE_WR_W;
                r_nxt.st    = S_WAIT_W;
            end
            S_WAIT_W:
            begin
                r_nxt.req = 1'b0;
                if (cyc.done)
                begin
                    // both forms end at the confirm write, last_step
                    if (r_r.k == last_step(r_r.rng, r_r.bm))
                    begin
                        r_nxt.pc = '0;
                        r_nxt.st = S_POLL;
                    end
                    else
                    begin
                        r_nxt.k  = r_r.k + 5'd1;
                        r_nxt.st = S_ISSUE;
                    end
                end
            end
            S_POLL:
            begin
                r_nxt.req   = 1'b1;
                r_nxt.wr    = 1'b0;
                r_nxt.addr  = ADDR_ZERO;
                r_nxt.wdata = RSV_WORD;
                r_nxt.oe    = r_r.bm ? OE_RD_B : OE_RD_W;
                r_nxt.st    = S_WAIT_R;
            end
            S_WAIT_R:
            begin
                r_nxt.req = 1'b0;
                if (cyc.done)
                begin
                    if (flash_ready_i)
                    begin
                        r_nxt.pass = 1'b1;
                        r_nxt.busy = 1'b0;
                        r_nxt.done = 1'b1;
                        r_nxt.st   = S_IDLE;
                    end
                    else if (cyc.rdata[POLL_ERR_BIT])
                    begin
                        r_nxt.fail = 1'b1;
                        r_nxt.st   = S_RST_ISSUE;
                    end
                    else if (r_r.pc == POLL_LIMIT)
                    begin
                        r_nxt.fail = 1'b1;
                        r_nxt.tmo  = 1'b1;
                        r_nxt.st   = S_RST_ISSUE;
                    end
                    else
                    begin
                        r_nxt.pc = r_r.pc + 32'h1;
                        r_nxt.st = S_POLL;
                    end
                end
            end
            S_RST_ISSUE:
            begin
                // read/reset brings a failed device back to read mode
                r_nxt.req   = 1'b1;
                r_nxt.wr    = 1'b1;
                r_nxt.addr  = ADDR_ZERO;
                r_nxt.wdata = r_r.bm ? {1'b0, DQ_MID_PAD,
                                        READ_RESET_CODE[7:0]}
                                     : READ_RESET_CODE;
                r_nxt.oe    = r_r.bm ? OE_WR_B : OE_WR_W;
                r_nxt.st    = S_RST_WAIT;
            end
            S_RST_WAIT:
            begin
                r_nxt.req = 1'b0;
                if (cyc.done)
                begin
                    r_nxt.busy = 1'b0;
                    r_nxt.done = 1'b1;
                    r_nxt.st   = S_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            r_r <= '0;
        else
            r_r <= r_nxt;
    end

    assign cyc.req   = r_r.req;
    assign cyc.wr    = r_r.wr;
    assign cyc.addr  = r_r.addr;
    assign cyc.wdata = r_r.wdata;
    assign cyc.oe    = r_r.oe;
    assign busy_o    = r_r.busy;
    assign done_o    = r_r.done;
    assign pass_o    = r_r.pass;
    assign fail_o    = r_r.fail;
    assign timeout_o = r_r.tmo;

    crcv_cycle u_cycle (
        .clk_i         (clk_i),
        .rst_i         (rst_i),
        .cyc           (cyc.eng),
        .flash_dq_i    (flash_dq_i),
        .flash_addr_o  (flash_addr_o),
        .flash_dq_o    (flash_dq_o),
        .flash_dq_oe_o (flash_dq_oe_o),
        .flash_ce_n_o  (flash_ce_n_o),
        .flash_we_n_o  (flash_we_n_o),
        .flash_oe_n_o  (flash_oe_n_o)
    );

    //------------------------------------------------------------------
    // checks
    //------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    localparam logic [4:0] K_CRC_LO_B = STEP_UNIT0 + 5'(U_CRC0 << 1);
    localparam logic [4:0] K_STA_LO_W = STEP_UNIT0 + U_STA_LO;
    localparam logic [4:0] K_STO_HI_W = STEP_UNIT0 + U_STO_HI;
    localparam logic [4:0] K_CONF_CW  = STEP_UNIT0 + UNITS_CHIP;

    sequence s_taken;
        r_r.st == S_IDLE && start_i;
    endsequence
    sequence s_wreq(logic [4:0] step);
        cyc.req && cyc.wr && r_r.k == step && r_r.st == S_WAIT_W;
    endsequence
    sequence s_wdone(logic [4:0] step);
        r_r.st == S_WAIT_W && r_r.k == step && cyc.done;
    endsequence

    a_unlock_first: assert property (s_taken |-> ##2 (s_wreq(STEP_UL1)
        && cyc.wdata[7:0] == DATA_UL1[7:0]))
        else $error("first write is not the first unlock");
    a_unlock_second: assert property (s_wdone(STEP_UL1) |-> ##2
        (s_wreq(STEP_UL2) && cyc.wdata[7:0] == DATA_UL2[7:0]))
        else $error("second unlock missing");
    a_count_range: assert property (s_wreq(STEP_CNT) && r_r.rng
        && !r_r.bm |-> cyc.wdata == CNT_RANGE_W)
        else $error("wrong range word count");
    a_count_chip: assert property (s_wreq(STEP_CNT) && !r_r.rng
        && r_r.bm |-> cyc.wdata[7:0] == CNT_CHIP_B[7:0])
        else $error("wrong chip byte count");
    a_option_word: assert property (s_wreq(STEP_UNIT0) && !r_r.bm
        |-> cyc.wdata == (r_r.rng ? OPT_RANGE : OPT_CHIP))
        else $error("wrong option word");
    a_crc_low_byte: assert property (s_wreq(K_CRC_LO_B) && r_r.bm |->
        cyc.wdata[7:0] == r_r.crc[7:0] && !cyc.wdata[15])
        else $error("crc low byte not first");
    a_start_low: assert property (s_wreq(K_STA_LO_W) && r_r.rng
        && !r_r.bm |-> cyc.addr == 24'(U_STA_LO)
        && cyc.wdata == r_r.sa[15:0])
        else $error("start low word wrong");
    a_stop_high: assert property (s_wreq(K_STO_HI_W) && r_r.rng
        && !r_r.bm |-> cyc.addr == 24'(U_STO_HI)
        && cyc.wdata == r_r.so[31:16])
        else $error("stop high word wrong");
    a_chip_confirm: assert property (s_wreq(K_CONF_CW) && !r_r.rng
        && !r_r.bm |-> cyc.wdata == CMD_CONFIRM
        && cyc.addr == ADDR_ZERO)
        else $error("chip form confirm misplaced");
    a_poll_after: assert property (s_wdone(last_step(r_r.rng, r_r.bm))
        |-> ##2 (cyc.req && !cyc.wr))
        else $error("no poll read after confirm");
endmodule // crcv_host
`default_nettype wire

// ---- crcv_pkg.sv ----
/*
 * constants, types and command-sequence functions for the crc-64 verify
 * sequencer host.
 * assumes a 100 MHz clock and a parallel nor flash on the far side.
 */
`default_nettype none
package crcv_pkg;
    //------------------------------------------------------------------
    // timing
    //------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_WE_LOW_NS   = 50;
    localparam int T_HOLD_NS     = 30;
    localparam int T_ACC_NS      = 70;
    localparam logic [7:0] WE_LOW_CYC =
        8'((T_WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] HOLD_CYC =
        8'((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] ACC_CYC =
        8'((T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] CNT_ONE = 8'h01;

    //------------------------------------------------------------------
    // addresses and codes
    //------------------------------------------------------------------
    localparam logic [23:0] ADDR_ZERO  = 24'h000000;
    localparam logic [23:0] ADDR_UL1_W = 24'h000555;
    localparam logic [23:0] ADDR_UL2_W = 24'h0002aa;
    localparam logic [24:0] ADDR_UL1_B = 25'h0000aaa;
    localparam logic [24:0] ADDR_UL2_B = 25'h0000555;
    localparam logic [15:0] DATA_UL1    = 16'h00aa;
    localparam logic [15:0] DATA_UL2    = 16'h0055;
    localparam logic [15:0] CMD_EXT     = 16'h00eb;
    localparam logic [15:0] CMD_CRC     = 16'h0027;
    localparam logic [15:0] CMD_CONFIRM = 16'h0029;
    localparam logic [15:0] OPT_RANGE   = 16'hfffe;
    localparam logic [15:0] OPT_CHIP    = 16'hffff;
    localparam logic [15:0] RSV_WORD    = 16'h0000;
    localparam logic [15:0] CNT_RANGE_W = 16'h000a;
    localparam logic [15:0] CNT_CHIP_B  = 16'h0009;
    localparam logic [7:0]  BYTE_PAD    = 8'h00;
    localparam logic [6:0]  DQ_MID_PAD  = 7'h00;
    localparam int          POLL_ERR_BIT = 5;
    localparam logic [15:0] OE_WR_W = 16'hffff;
    localparam logic [15:0] OE_WR_B = 16'h80ff;
    localparam logic [15:0] OE_RD_W = 16'h0000;
    localparam logic [15:0] OE_RD_B = 16'h8000;

    //------------------------------------------------------------------
    // sequence steps and data units
    //------------------------------------------------------------------
    localparam logic [4:0] STEP_UL1   = 5'd0;
    localparam logic [4:0] STEP_UL2   = 5'd1;
    localparam logic [4:0] STEP_EXT   = 5'd2;
    localparam logic [4:0] STEP_SUB   = 5'd3;
    localparam logic [4:0] STEP_CNT   = 5'd4;
    localparam logic [4:0] STEP_UNIT0 = 5'd5;
    localparam logic [4:0] U_OPT = 5'd0, U_CRC0 = 5'd1, U_CRC1 = 5'd2;
    localparam logic [4:0] U_CRC2 = 5'd3, U_CRC3 = 5'd4;
    localparam logic [4:0] U_STA_LO = 5'd5, U_STA_HI = 5'd6;
    localparam logic [4:0] U_STO_LO = 5'd8, U_STO_HI = 5'd9;
    localparam logic [4:0] UNITS_RANGE = 5'd11;
    localparam logic [4:0] UNITS_CHIP  = 5'd5;

    typedef enum logic [1:0] {E_IDLE, E_SETUP, E_ACT, E_HOLD} crcv_eng_e;
    typedef enum logic [2:0] {S_IDLE, S_ISSUE, S_WAIT_W, S_POLL, S_WAIT_R,
                              S_RST_ISSUE, S_RST_WAIT} crcv_st_e;
    typedef struct packed {
        logic [23:0] waddr;
        logic        a_lsb;
        logic [15:0] data;
    } crcv_wr_s;

    function automatic logic [4:0] units(input logic rng);
        return rng ? UNITS_RANGE : UNITS_CHIP;
    endfunction

    // index of the confirm write
    function automatic logic [4:0] last_step(input logic rng, bm);
        return STEP_UNIT0 + (bm ? 5'(units(rng) << 1) : units(rng));
    endfunction

    function automatic logic [15:0] unit_word(input logic [4:0] u,
        input logic rng, input logic [63:0] crc, input logic [31:0] sa, so);
        unique case (u)
            U_OPT:    return rng ? OPT_RANGE : OPT_CHIP;
            U_CRC0:   return crc[15:0];
            U_CRC1:   return crc[31:16];
            U_CRC2:   return crc[47:32];
            U_CRC3:   return crc[63:48];
            U_STA_LO: return sa[15:0];
            U_STA_HI: return sa[31:16];
            U_STO_LO: return so[15:0];
            U_STO_HI: return so[31:16];
            default:  return RSV_WORD;
        endcase
    endfunction

    // address and data of write k of the crc command
    function automatic crcv_wr_s cmd_write(input logic [4:0] k,
        input logic rng, bm, input logic [63:0] crc, input logic [31:0] sa,
        input logic [31:0] so);
        crcv_wr_s    w;
        logic [4:0]  j;
        logic [15:0] uw;
        logic [23:0] wa;
        logic [24:0] boff;
        j    = k - STEP_UNIT0;
        uw   = unit_word(bm ? (j >> 1) : j, rng, crc, sa, so);
        wa   = ADDR_ZERO;
        boff = '0;
        w    = '0;
        if (k == STEP_UL1)
        begin
            wa     = ADDR_UL1_W;
            boff   = ADDR_UL1_B;
            w.data = DATA_UL1;
        end
        else if (k == STEP_UL2)
        begin
            wa     = ADDR_UL2_W;
            boff   = ADDR_UL2_B;
            w.data = DATA_UL2;
        end
        else if (k == STEP_EXT)
            w.data = CMD_EXT;
        else if (k == STEP_SUB)
            w.data = CMD_CRC;
        else if (k == STEP_CNT)
            w.data = {11'h000, bm ? 5'((units(rng) << 1) - 5'd1)
                                  : 5'(units(rng) - 5'd1)};
        else if (k < last_step(rng, bm))
        begin
            wa     = 24'(j);
            boff   = 25'(j);
            w.data = !bm ? uw : (j[0] ? {BYTE_PAD, uw[15:8]}
                                      : {BYTE_PAD, uw[7:0]});
        end
        else
            w.data = CMD_CONFIRM;
        w.waddr = bm ? boff[24:1] : wa;
        w.a_lsb = bm & boff[0];
        return w;
    endfunction
endpackage
`default_nettype wire

// ---- crcv_cyc_if.sv ----
/*
 * one bus cycle request between the sequencer and its cycle engine.
 * assumes both ends share one clock; req is held for one cycle.
 */
`default_nettype none
interface crcv_cyc_if;
    logic        req;
    logic        wr;
    logic [23:0] addr;
    logic [15:0] wdata;
    logic [15:0] oe;
    logic        done;
    logic [15:0] rdata;
    modport ctl (output req, wr, addr, wdata, oe, input done, rdata);
    modport eng (input req, wr, addr, wdata, oe, output done, rdata);
endinterface
`default_nettype wire

// ---- crcv_cycle.sv ----
/*
 * flash bus cycle engine: one write or read cycle per request.
 * assumes flash_dq_i is synchronous to clk_i.
 */
`default_nettype none
module crcv_cycle
    import crcv_pkg::*;
(
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    crcv_cyc_if.eng    cyc,
    input  wire logic [15:0] flash_dq_i,
    output logic [23:0] flash_addr_o,
    output logic [15:0] flash_dq_o,
    output logic [15:0] flash_dq_oe_o,
    output logic        flash_ce_n_o,
    output logic        flash_we_n_o,
    output logic        flash_oe_n_o
);
    import crcv_pkg::*;

    typedef struct packed {
        crcv_eng_e   st;
        logic        wr;
        logic [7:0]  cnt;
        logic        ce_n;
        logic        we_n;
        logic        oe_n;
        logic [23:0] addr;
        logic [15:0] dq;
        logic [15:0] dq_oe;
        logic [15:0] rdata;
        logic        done;
    } crcv_eng_s;

    localparam crcv_eng_s ENG_RST = '{st: E_IDLE, wr: 1'b0, cnt: 8'h00,
        ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: 24'h000000,
        dq: 16'h0000, dq_oe: 16'h0000, rdata: 16'h0000, done: 1'b0};

    crcv_eng_s r_r;
    crcv_eng_s r_nxt;

    //------------------------------------------------------------------
    // cycle sequencing
    //------------------------------------------------------------------
    always_comb
    begin
        r_nxt      = r_r;
        r_nxt.done = 1'b0;
        unique case (r_r.st)
            E_IDLE:
                if (cyc.req)
                begin
                    r_nxt.st    = E_SETUP;
                    r_nxt.wr    = cyc.wr;
                    r_nxt.addr  = cyc.addr;
                    r_nxt.dq    = cyc.wdata;
                    r_nxt.dq_oe = cyc.oe;
                    r_nxt.ce_n  = 1'b0;
                end
            E_SETUP:
            begin
                r_nxt.st   = E_ACT;
                r_nxt.cnt  = r_r.wr ? WE_LOW_CYC : ACC_CYC;
                r_nxt.we_n = !r_r.wr;
                r_nxt.oe_n = r_r.wr;
            end
            E_ACT:
                if (r_r.cnt == CNT_ONE)
                begin
                    r_nxt.st   = E_HOLD;
                    r_nxt.we_n = 1'b1;
                    r_nxt.oe_n = 1'b1;
                    r_nxt.cnt  = HOLD_CYC;
                    if (!r_r.wr)
                        r_nxt.rdata = flash_dq_i;
                end
                else
                    r_nxt.cnt = r_r.cnt - CNT_ONE;
            E_HOLD:
                if (r_r.cnt == CNT_ONE)
                begin
                    r_nxt.st    = E_IDLE;
                    r_nxt.ce_n  = 1'b1;
                    r_nxt.dq_oe = OE_RD_W;
                    r_nxt.done  = 1'b1;
                end
                else
                    r_nxt.cnt = r_r.cnt - CNT_ONE;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            r_r <= ENG_RST;
        else
            r_r <= r_nxt;
    end

    assign cyc.done      = r_r.done;
    assign cyc.rdata     = r_r.rdata;
    assign flash_addr_o  = r_r.addr;
    assign flash_dq_o    = r_r.dq;
    assign flash_dq_oe_o = r_r.dq_oe;
    assign flash_ce_n_o  = r_r.ce_n;
    assign flash_we_n_o  = r_r.we_n;
    assign flash_oe_n_o  = r_r.oe_n;
endmodule // crcv_cycle
`default_nettype wire

// ---- crcv_flash_model.sv ----
/* behavioural nor flash answering the crc-64 verify command.
   assumes host pins change only on clk_i edges. */
`default_nettype none
module crcv_flash_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        bm_i,
    input  wire logic        hang_i,
    input  wire logic [23:0] addr_i,
    input  wire logic [15:0] dq_i,
    input  wire logic        ce_n_i,
    input  wire logic        we_n_i,
    input  wire logic        oe_n_i,
    output logic             ready_o,
    output logic [15:0]      dq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // command decode, crc engine, polling status
    // ------------------------------------------------------------
    localparam logic [7:0] CODE [4] = '{8'haa, 8'h55, 8'heb, 8'h27};
    logic [7:0]  mem [16];
    logic [15:0] u [11];
    logic [15:0] v;
    logic [15:0] last = '0;
    logic [24:0] ba;
    logic [4:0]  k, n;
    logic        we_q, err, pend;
    int          cnt;
    initial
        for (int i = 0; i < 16; i++)
            mem[i] = 8'(i * 29 + 3);
    function automatic logic [63:0] crc_of(int lo, int hi);
        logic [63:0] c;
        c = '0;
        for (int i = lo; i <= hi; i++)
            for (int b = 0; b < 8; b++)
                c = {c[62:0], 1'b0} ^ ((c[63] ^ mem[i][b])
                    ? 64'h42f0e1eba9ea3693 : 64'h0);
        return c;
    endfunction
    always @(negedge clk_i or posedge rst_i)
        if (rst_i)
        begin
            k = 0;
            cnt = 0;
            err = 0;
            we_q = 1;
            ready_o = 1;
        end
        else
        begin
            v = bm_i ? {8'h00, dq_i[7:0]} : dq_i;
            ba = {addr_i, dq_i[15]};
            if (cnt == 1 && !hang_i)
            begin
                ready_o = pend;
                err = !pend;
            end
            if (cnt > 1 || (cnt == 1 && !hang_i))
                cnt--;
            if (!we_q && we_n_i && !ce_n_i && cnt == 0)
            begin
                if (err)
                begin
                    err = v[7:0] != 8'hf0;
                    ready_o = !err;
                end
                else if (k < 4)
                    k = v[7:0] == CODE[k] ? k + 5'd1 : 5'd0;
                else if (k == 4)
                begin
                    n = v[4:0];
                    k = 5;
                end
                else if (k <= 5 + n)
                begin
                    if (!bm_i)
                        u[addr_i[3:0]] = v;
                    else if (ba[0])
                        u[ba[4:1]][15:8] = v[7:0];
                    else
                        u[ba[4:1]][7:0] = v[7:0];
                    k++;
                end
                else
                begin
                    if (v[7:0] == 8'h29)
                    begin
                        cnt = 20;
                        ready_o = 0;
                        pend = (u[0] == 16'hfffe &&
                            {u[9], u[8]} <= {u[6], u[5]}) ||
                            {u[4], u[3], u[2], u[1]} ==
                            (u[0] == 16'hfffe
                            ? crc_of(int'(u[5][3:0]), int'(u[8][3:0]))
                            : crc_of(0, 15));
                    end
                    k = 0;
                end
            end
            we_q = we_n_i;
        end
    always_comb
        if (!ce_n_i && !oe_n_i)
            dq_o = (cnt != 0 || err) ? {10'h000, err, 5'h00}
                 : {mem[{addr_i[2:0], 1'b1}], mem[{addr_i[2:0], 1'b0}]};
        else
            dq_o = ~last;
    always @(posedge clk_i)
        if (!ce_n_i && !oe_n_i)
            last <= dq_o;
endmodule // crcv_flash_model
`default_nettype wire

// ---- tb.sv ----
/* self-checking bench for crcv_host against the flash model.
   assumes a 100 MHz clock and POLL_LIMIT of 8. */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // stimulus, write monitor and verdict
    // ------------------------------------------------------------
    logic clk_i = 0, rst_i, start_i, range_i, byte_mode_i, hang, rdy;
    logic done_o, pass_o, fail_o, timeout_o, ce_n, we_n, oe_n, we_q = 1, busy;
    logic [63:0] exp_crc_i;
    logic [31:0] start_addr_i, stop_addr_i;
    logic [23:0] f_addr;
    logic [15:0] f_dq, f_din, f_oe;
    logic [40:0] wq[$];
    logic [2:0]  rq[$];
    integer      seed = 32'h9b522fba;
    int          miscompares = 0, tests_run = 0;
    initial forever #5 clk_i = ~clk_i;
    crcv_host #(.POLL_LIMIT(32'd8)) u_crcv_host (.clk_i(clk_i),
        .rst_i(rst_i), .start_i(start_i), .range_i(range_i),
        .byte_mode_i(byte_mode_i), .exp_crc_i(exp_crc_i),
        .start_addr_i(start_addr_i), .stop_addr_i(stop_addr_i),
        .flash_ready_i(rdy), .flash_dq_i(f_din), .flash_addr_o(f_addr),
        .flash_dq_o(f_dq), .flash_dq_oe_o(f_oe), .flash_ce_n_o(ce_n),
        .flash_we_n_o(we_n), .flash_oe_n_o(oe_n), .busy_o(busy),
        .done_o(done_o), .pass_o(pass_o), .fail_o(fail_o),
        .timeout_o(timeout_o));
    crcv_flash_model u_crcv_flash_model (.clk_i(clk_i), .rst_i(rst_i),
        .bm_i(byte_mode_i), .hang_i(hang), .addr_i(f_addr), .dq_i(f_dq),
        .ce_n_i(ce_n), .we_n_i(we_n), .oe_n_i(oe_n), .ready_o(rdy),
        .dq_o(f_din));
    task automatic check(string what, logic [40:0] e, logic [40:0] s);
        tests_run++;
        if (e !== s)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, e, s);
        end
    endtask
    always @(posedge clk_i)
    begin
        if (!we_q && we_n && !ce_n)
            check("write", wq.pop_front(), {f_addr, byte_mode_i & f_dq[15],
                byte_mode_i ? {8'h00, f_dq[7:0]} : f_dq});
        if (!we_q && we_n && !ce_n)
            check("oe", 41'({byte_mode_i ? 16'h80ff : 16'hffff, 1'b1}),
                41'({f_oe, busy}));
        if (done_o)
            check("result", 41'(rq.pop_front()),
                41'({pass_o, fail_o, timeout_o}));
        we_q <= we_n;
    end
    task automatic push_w(logic b, logic [24:0] a, logic [15:0] d);
        wq.push_back(b ? {a, 8'h00, d[7:0]} : {a[23:0], 1'b0, d});
    endtask
    task automatic run(logic r, logic b, logic [63:0] c, logic [31:0] sa,
        logic [31:0] so, logic [2:0] res);
        logic [15:0] un [11];
        int          nu;
        un = '{r ? 16'hfffe : 16'hffff, c[15:0], c[31:16], c[47:32],
            c[63:48], sa[15:0], sa[31:16], 16'h0, so[15:0], so[31:16], 16'h0};
        nu = r ? 11 : 5;
        push_w(b, b ? 25'haaa : 25'h555, 16'h00aa);
        push_w(b, b ? 25'h555 : 25'h2aa, 16'h0055);
        push_w(b, 0, 16'h00eb);
        push_w(b, 0, 16'h0027);
        push_w(b, 0, b ? 16'(2 * nu - 1) : 16'(nu - 1));
        for (int i = 0; i < nu; i++)
            if (b)
            begin
                push_w(b, 25'(2 * i), {8'h00, un[i][7:0]});
                push_w(b, 25'(2 * i + 1), {8'h00, un[i][15:8]});
            end
            else
                push_w(b, 25'(i), un[i]);
        push_w(b, 0, 16'h0029);
        if (res[1])
            push_w(b, 0, 16'h00f0);
        rq.push_back(res);
        @(posedge clk_i);
        {range_i, byte_mode_i, exp_crc_i} <= {r, b, c};
        {start_addr_i, stop_addr_i, start_i} <= {sa, so, 1'b1};
        repeat (3) @(posedge clk_i);
        start_i <= 0;
        for (int t = 0; t < 3000 && done_o !== 1'b1; t++)
            @(negedge clk_i);
        repeat (3) @(posedge clk_i);
    endtask
    task automatic end_sim;
        miscompares += wq.size() + rq.size();
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        {rst_i, start_i, range_i, byte_mode_i, hang} = 5'b10000;
        {exp_crc_i, start_addr_i, stop_addr_i} = '0;
        repeat (2) @(posedge clk_i);
        rst_i <= 0;
        run(0, 0, u_crcv_flash_model.crc_of(0, 15), 0, 0, 3'b100);
        run(0, 1, u_crcv_flash_model.crc_of(0, 15), 0, 0, 3'b100);
        run(1, 0, u_crcv_flash_model.crc_of(2, 9), 2, 9, 3'b100);
        run(1, 1, {$random(seed), $random(seed)}, 3, 12, 3'b010);
        run(1, 0, {$random(seed), $random(seed)}, 9, 4, 3'b100);
        hang <= 1;
        run(0, 0, u_crcv_flash_model.crc_of(0, 15), 0, 0, 3'b011);
        end_sim;
    end
    initial
    begin
        #200us;
        miscompares++;
        end_sim;
    end
endmodule // tb
`default_nettype wire
